// >>> hw/pupc_ctrl.sv
// profile select, update strobe, power-down and gpio control block
`timescale 1ns/10ps
module pupc_ctrl (
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    // register port from the serial control logic
    input  wire logic        i_reg_wr,
    input  wire logic [2:0]  i_reg_sel,
    input  wire logic [31:0] i_reg_wdata,
    output logic      [31:0] o_reg_rdata,
    // profile and update pins
    input  wire logic [2:0]  i_profile_pins,
    input  wire logic        i_update_pin,
    output logic             o_update_pin,
    output logic             o_update_pin_oe,
    input  wire logic        i_external_sleep_pin,
    // active profile and update event towards the core
    output logic      [2:0]  o_active_profile,
    output logic             o_apply_update,
    // active copy of the update-gated control_word_two controls
    output logic      [31:0] o_active_ctrl2,
    // section power-down outputs
    output logic             o_pd_digital,
    output logic             o_pd_main_dac,
    output logic             o_pd_main_dac_bias,
    output logic             o_pd_aux_dac,
    output logic             o_pd_refclk,
    output logic             o_pd_pll_osc,
    // data pins used as gpio (16 usable, D5:D4 excluded)
    input  wire logic [15:0] i_gpio_pins,
    output logic      [15:0] o_gpio_pins,
    output logic      [15:0] o_gpio_pins_oe
);
    typedef struct packed {
        logic [31:0] ctrl1;
        logic [31:0] ctrl2_buf;
        logic [31:0] ctrl2_act;
        logic [31:0] rate_buf;
        logic [31:0] rate_act;
        logic [15:0] gpdir;
        logic [15:0] gpval;
        logic [2:0]  prof_prev;
        logic [2:0]  prof_act;
        logic        upd_prev;
        logic [3:0]  pulse_cnt;
        logic        upd_out;
        logic        upd_oe;
        logic        apply;
        logic [31:0] rdata;
        logic [5:0]  pd;
        logic [15:0] gp_out;
        logic [15:0] gp_oe;
    } pupc_ctrl_s;
    pupc_ctrl_s st_reg;
    pupc_ctrl_s st_next;

    logic [2:0]  prof_s;
    logic        upd_s;
    logic        sleep_s;
    logic [15:0] gpin_s;
    logic        auto_on;
    logic        fire;
    logic        static_hi;
    logic        ext_edge;
    logic        prof_chg;
    logic        upd_evt;
    logic        wr_ok;
    logic        gpio_on;
    logic [15:0] gp_read;

    // pins from outside pass two flip-flops first
    pupc_sync2 #(.W(21)) u_sync (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_async ({i_profile_pins, i_update_pin, i_external_sleep_pin, i_gpio_pins}),
        .o_sync  ({prof_s, upd_s, sleep_s, gpin_s})
    );

    // automatic update rate generator on the active rate settings
    pupc_rate_gen u_rate (
        .i_mclk     (i_mclk),
        .i_nrst     (i_nrst),
        .i_enable   (auto_on && !static_hi),
        .i_rate_sel (st_reg.ctrl2_act[pupc_pkg::RATE_LO +: 2]),
        .i_count    (st_reg.rate_act),
        .o_fire     (fire)
    );

    // event sources and gating terms
    always_comb begin
        auto_on   = st_reg.ctrl2_act[pupc_pkg::AUTO_UPD];
        static_hi = auto_on && (st_reg.rate_act <= pupc_pkg::RATE_STATIC_MAX);
        ext_edge  = !auto_on && upd_s && !st_reg.upd_prev;
        prof_chg  = (prof_s != st_reg.prof_prev);
        upd_evt   = ext_edge || prof_chg || (auto_on && fire);
        // writes blocked in digital power-down, except the clearing write
        wr_ok     = i_reg_wr && (!o_pd_digital ||
                    (i_reg_sel == pupc_pkg::SEL_CTRL1 &&
                     !i_reg_wdata[pupc_pkg::PD_DIGITAL]));
        gpio_on   = st_reg.ctrl1[pupc_pkg::UPCONV_MODE] &&
                    st_reg.ctrl1[pupc_pkg::SER_BASEBAND];
        gp_read   = (st_reg.gpdir & st_reg.gpval) | (~st_reg.gpdir & gpin_s);
    end

    // next state: registers, update transfer, strobe pulse, outputs
    always_comb begin
        st_next           = st_reg;
        st_next.prof_prev = prof_s;
        st_next.upd_prev  = upd_s;
        st_next.apply     = upd_evt;
        if (wr_ok) begin
            unique case (i_reg_sel)
                pupc_pkg::SEL_CTRL1: st_next.ctrl1     = i_reg_wdata;
                pupc_pkg::SEL_CTRL2: st_next.ctrl2_buf = i_reg_wdata;
                pupc_pkg::SEL_RATE:  st_next.rate_buf  = i_reg_wdata;
                pupc_pkg::SEL_GPDIR: st_next.gpdir     = i_reg_wdata[15:0];
                pupc_pkg::SEL_GPVAL: st_next.gpval     = i_reg_wdata[15:0];
                default: ;
            endcase
        end
        // buffered values become active only on an update event
        if (upd_evt) begin
            st_next.ctrl2_act = st_reg.ctrl2_buf;
            st_next.rate_act  = st_reg.rate_buf;
            st_next.prof_act  = prof_s;
        end
        // strobe pin drive in automatic mode
        st_next.upd_oe = auto_on;
        if (!auto_on) begin
            st_next.pulse_cnt = 4'h0;
            st_next.upd_out   = 1'b0;
        end else if (static_hi) begin
            st_next.pulse_cnt = 4'h0;
            st_next.upd_out   = 1'b1;
        end else if (fire) begin
            st_next.pulse_cnt = 4'(pupc_pkg::UPD_PULSE_CYC - 1);
            st_next.upd_out   = 1'b1;
        end else if (st_reg.pulse_cnt != 4'h0) begin
            st_next.pulse_cnt = st_reg.pulse_cnt - 4'h1;
            st_next.upd_out   = 1'b1;
        end else begin
            st_next.upd_out   = 1'b0;
        end
        // power-down: pin overrides software bits
        if (sleep_s) begin
            st_next.pd[0] = 1'b1;
            st_next.pd[1] = 1'b1;
            st_next.pd[3] = 1'b1;
            st_next.pd[2] = 1'b1;
            st_next.pd[4] = !st_reg.ctrl1[pupc_pkg::EXT_PD_FAST];
            st_next.pd[5] = !st_reg.ctrl1[pupc_pkg::EXT_PD_FAST];
        end else begin
            st_next.pd[0] = st_reg.ctrl1[pupc_pkg::PD_DIGITAL];
            st_next.pd[1] = st_reg.ctrl1[pupc_pkg::PD_MAIN_DAC];
            st_next.pd[2] = st_reg.ctrl1[pupc_pkg::PD_AUX_DAC];
            st_next.pd[3] = st_reg.ctrl1[pupc_pkg::PD_REFCLK];
            st_next.pd[4] = st_reg.ctrl1[pupc_pkg::PD_MAIN_DAC];
            st_next.pd[5] = st_reg.ctrl1[pupc_pkg::PD_REFCLK];
        end
        // gpio pins: bit i drives its mapped data pin
        st_next.gp_out = st_reg.gpval;
        st_next.gp_oe  = gpio_on ? st_reg.gpdir : 16'h0000;
        // read data
        unique case (i_reg_sel)
            pupc_pkg::SEL_CTRL1:  st_next.rdata = st_reg.ctrl1;
            pupc_pkg::SEL_CTRL2:  st_next.rdata = st_reg.ctrl2_buf;
            pupc_pkg::SEL_RATE:   st_next.rdata = st_reg.rate_buf;
            pupc_pkg::SEL_GPDIR:  st_next.rdata = {16'h0000, st_reg.gpdir};
            pupc_pkg::SEL_GPVAL:  st_next.rdata = {16'h0000, gp_read};
            pupc_pkg::SEL_STATUS: st_next.rdata = {23'h000000, st_reg.pd,
                                                   st_reg.prof_act};
            default:              st_next.rdata = 32'h0000_0000;
        endcase
    end

    // state register with synchronous reset
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            st_reg           <= '0;
            st_reg.ctrl1     <= pupc_pkg::CTRL1_RST;
            st_reg.ctrl2_buf <= pupc_pkg::CTRL2_RST;
            st_reg.ctrl2_act <= pupc_pkg::CTRL2_RST;
            st_reg.rate_buf  <= pupc_pkg::RATE_RST;
            st_reg.rate_act  <= pupc_pkg::RATE_RST;
            st_reg.gpdir     <= pupc_pkg::GPIO_RST;
            st_reg.gpval     <= pupc_pkg::GPIO_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign o_reg_rdata        = st_reg.rdata;
    assign o_update_pin       = st_reg.upd_out;
    assign o_update_pin_oe    = st_reg.upd_oe;
    assign o_active_profile   = st_reg.prof_act;
    assign o_apply_update     = st_reg.apply;
    assign o_active_ctrl2     = st_reg.ctrl2_act;
    assign o_pd_digital       = st_reg.pd[0];
    assign o_pd_main_dac      = st_reg.pd[1];
    assign o_pd_aux_dac       = st_reg.pd[2];
    assign o_pd_refclk        = st_reg.pd[3];
    assign o_pd_main_dac_bias = st_reg.pd[4];
    assign o_pd_pll_osc       = st_reg.pd[5];
    assign o_gpio_pins        = st_reg.gp_out;
    assign o_gpio_pins_oe     = st_reg.gp_oe;
endmodule : pupc_ctrl

// >>> hw/pupc_pkg.sv
// package of constants for the profile, update, power and gpio control block
package pupc_pkg;
    // register access selectors (no offsets printed; local register selects)
    localparam logic [2:0] SEL_CTRL1   = 3'h0;  // control_word_one: power-down bits
    localparam logic [2:0] SEL_CTRL2   = 3'h1;  // control_word_two: update controls
    localparam logic [2:0] SEL_RATE    = 3'h2;  // update_rate_count
    localparam logic [2:0] SEL_GPDIR   = 3'h3;  // gpio_direction
    localparam logic [2:0] SEL_GPVAL   = 3'h4;  // gpio_value
    localparam logic [2:0] SEL_STATUS  = 3'h5;  // active profile and power state
    // control_word_one field positions
    localparam int PD_DIGITAL    = 0;
    localparam int PD_MAIN_DAC   = 1;
    localparam int PD_AUX_DAC    = 2;
    localparam int PD_REFCLK     = 3;
    localparam int EXT_PD_FAST   = 4;
    localparam int UPCONV_MODE   = 5;   // quadrature_upconvert_mode
    localparam int SER_BASEBAND  = 6;   // two-pin serial baseband interface
    // control_word_two field positions
    localparam int AUTO_UPD      = 0;
    localparam int RATE_LO       = 1;   // 2-bit rate field at [2:1]
    // reset values
    localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL2_RST = 32'h0000_0000;
    localparam logic [31:0] RATE_RST  = 32'h0000_0000;
    localparam logic [15:0] GPIO_RST  = 16'h0000;
    // timing
    localparam int          UPD_PULSE_CYC = 12;
    localparam logic [31:0] RATE_STATIC_MAX = 32'h0000_0003;
    localparam int          QUARTER_DIV = 4;
endpackage : pupc_pkg

// >>> hw/pupc_sync2.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pupc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_mclk,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } pupc_sync_s;
    pupc_sync_s st_reg;
    pupc_sync_s st_next;

    // shift pins through two stages
    always_comb begin
        st_next.first  = i_async;
        st_next.second = st_reg.first;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sync = st_reg.second;
endmodule : pupc_sync2

// >>> hw/pupc_rate_gen.sv
// automatic update rate generator: quarter-rate prescale, 2^A divide, 32-bit count
`timescale 1ns/10ps
module pupc_rate_gen (
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_enable,
    input  wire logic [1:0]  i_rate_sel,
    input  wire logic [31:0] i_count,
    output logic             o_fire
);
    typedef struct packed {
        logic [1:0]  pre;
        logic [2:0]  div;
        logic [31:0] cnt;
        logic        fire;
    } pupc_rate_s;
    pupc_rate_s st_reg;
    pupc_rate_s st_next;
    logic       quarter_tick;
    logic       div_tick;
    logic [2:0] div_max;

    // quarter-rate tick, then divide by 1, 2, 4 or 8, then count B ticks
    always_comb begin
        st_next      = st_reg;
        st_next.fire = 1'b0;
        quarter_tick = (st_reg.pre == 2'(pupc_pkg::QUARTER_DIV - 1));
        div_max      = 3'((4'h1 << i_rate_sel) - 4'h1);
        div_tick     = quarter_tick && (st_reg.div >= div_max);
        if (!i_enable) begin
            st_next.pre = 2'h0;
            st_next.div = 3'h0;
            st_next.cnt = 32'h0000_0000;
        end else begin
            st_next.pre = st_reg.pre + 2'h1;
            if (quarter_tick) begin
                st_next.div = div_tick ? 3'h0 : st_reg.div + 3'h1;
            end
            if (div_tick) begin
                if (st_reg.cnt + 32'h1 >= i_count) begin
                    st_next.cnt  = 32'h0000_0000;
                    st_next.fire = 1'b1;
                end else begin
                    st_next.cnt = st_reg.cnt + 32'h1;
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_fire = st_reg.fire;
endmodule : pupc_rate_gen

// >>> dv/pupc_ctrl_asserts.sv
// port assertions for the profile, update, power and gpio block
`timescale 1ns/10ps
module pupc_ctrl_asserts (
    input wire logic        i_mclk,
    input wire logic        i_nrst,
    input wire logic [2:0]  i_reg_sel,
    input wire logic [31:0] o_reg_rdata,
    input wire logic [2:0]  i_profile_pins,
    input wire logic        i_update_pin,
    input wire logic        o_update_pin,
    input wire logic        o_update_pin_oe,
    input wire logic        i_external_sleep_pin,
    input wire logic [2:0]  o_active_profile,
    input wire logic        o_apply_update,
    input wire logic        o_pd_digital,
    input wire logic        o_pd_main_dac,
    input wire logic        o_pd_main_dac_bias,
    input wire logic        o_pd_aux_dac,
    input wire logic        o_pd_refclk,
    input wire logic        o_pd_pll_osc,
    input wire logic [15:0] i_gpio_pins,
    input wire logic [15:0] o_gpio_pins_oe
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // pin events lead to one update pulse in bounded time
    property p_strobe;
        $rose(i_update_pin) && !o_update_pin_oe |-> ##[2:4] o_apply_update;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe gave no update");
    property p_prof_chg;
        $changed(i_profile_pins) |-> ##[2:4] o_apply_update;
    endproperty
    a_prof_chg: assert property (p_prof_chg) else $error("profile change gave no update");
    property p_prof_val;
        $stable(i_profile_pins)[*5] ##0 o_apply_update |-> o_active_profile == i_profile_pins;
    endproperty
    a_prof_val: assert property (p_prof_val) else $error("wrong active profile");
    // consecutive driven-high cycles on the strobe pin, saturating
    logic [4:0] hi_cnt;
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            hi_cnt <= 5'h00;
        end else if (o_update_pin && o_update_pin_oe) begin
            hi_cnt <= (hi_cnt == 5'h1F) ? 5'h1F : hi_cnt + 5'h01;
        end else begin
            hi_cnt <= 5'h00;
        end
    end
    // auto strobe pulse is twelve cycles wide
    property p_pulse_hi;
        $fell(o_update_pin) && o_update_pin_oe |-> hi_cnt >= 5'h0C;
    endproperty
    a_pulse_hi: assert property (p_pulse_hi) else $error("strobe pulse short");
    property p_pulse_fall;
        $fell(o_update_pin) && o_update_pin_oe |-> $past(o_update_pin, 12) && !$past(o_update_pin, 13);
    endproperty
    a_pulse_fall: assert property (p_pulse_fall) else $error("strobe pulse long");
    // sleep pin forces sections down
    property p_sleep;
        i_external_sleep_pin[*4] |=> o_pd_digital && o_pd_main_dac && o_pd_aux_dac && o_pd_refclk;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep pin not obeyed");
    property p_sleep_mode;
        i_external_sleep_pin[*4] |=> o_pd_main_dac_bias == o_pd_pll_osc;
    endproperty
    a_sleep_mode: assert property (p_sleep_mode) else $error("sleep mode split");
    // input pins read back through the data register
    property p_gpio_rd;
        (i_reg_sel == pupc_pkg::SEL_GPVAL && $stable(i_gpio_pins) && $stable(o_gpio_pins_oe))[*4]
        |-> ((o_reg_rdata[15:0] ^ i_gpio_pins) & ~o_gpio_pins_oe) == 16'h0000;
    endproperty
    a_gpio_rd: assert property (p_gpio_rd) else $error("gpio input read wrong");
endmodule : pupc_ctrl_asserts

// >>> dv/pupc_pins_model.sv
// far-side pin driver: profile, update strobe, sleep and gpio levels
`timescale 1ns/10ps
module pupc_pins_model (
    input  wire logic        i_mclk,
    input  wire logic [15:0] i_drv,
    input  wire logic [15:0] i_drv_oe,
    output logic      [2:0]  o_profile,
    output logic             o_strobe,
    output logic             o_sleep,
    output logic      [15:0] o_level
);
    logic [15:0] ext_lvl = 16'h0000;
    // resolved pin level, device wins where it drives
    assign o_level = (i_drv & i_drv_oe) | (ext_lvl & ~i_drv_oe);
    initial begin
        o_profile = 3'h0;
        o_strobe = 1'b0;
        o_sleep = 1'b0;
    end
    // binary profile index, held at least a cycle
    task automatic set_profile(input logic [2:0] p);
        @(negedge i_mclk) o_profile = p;
    endtask : set_profile
    // rising update edge after the writes, held hi cycles
    task automatic strobe(input int hi);
        @(negedge i_mclk) o_strobe = 1'b1;
        repeat (hi) @(negedge i_mclk);
        o_strobe = 1'b0;
    endtask : strobe
    task automatic set_pins(input logic s, input logic [15:0] v);
        @(negedge i_mclk) o_sleep = s;
        ext_lvl = v;
    endtask : set_pins
endmodule : pupc_pins_model

// >>> dv/tb_pupc_ctrl.sv
// self-checking bench for the profile, update, power and gpio block
`timescale 1ns/10ps
module tb_pupc_ctrl;
    logic        i_mclk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_reg_wr = 1'b0;
    logic [2:0]  i_reg_sel = 3'h0;
    logic [31:0] i_reg_wdata = 32'h0;
    logic [31:0] o_reg_rdata, o_active_ctrl2, rv;
    logic [2:0]  i_profile_pins, o_active_profile;
    logic        i_update_pin, o_update_pin, o_update_pin_oe, i_external_sleep_pin;
    logic        o_apply_update, o_pd_digital, o_pd_main_dac, o_pd_main_dac_bias;
    logic        o_pd_aux_dac, o_pd_refclk, o_pd_pll_osc;
    logic [15:0] i_gpio_pins, o_gpio_pins, o_gpio_pins_oe, dir, val, ext;
    int          n_fail = 0;
    int          n_tests = 0;
    int          seed = 32'h02DD77D0;
    int          gap;
    always #10 i_mclk = ~i_mclk;
    pupc_ctrl DUT (.*);
    pupc_pins_model m (.i_mclk, .i_drv(o_gpio_pins), .i_drv_oe(o_gpio_pins_oe),
        .o_profile(i_profile_pins), .o_strobe(i_update_pin),
        .o_sleep(i_external_sleep_pin), .o_level(i_gpio_pins));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] s, input logic [31:0] d);
        @(negedge i_mclk);
        i_reg_wr = 1'b1;
        i_reg_sel = s;
        i_reg_wdata = d;
        @(negedge i_mclk);
        i_reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] s, output logic [31:0] d);
        @(negedge i_mclk) i_reg_sel = s;
        @(negedge i_mclk) d = o_reg_rdata;
    endtask : rd
    // bounded wait for the update pulse, n = cycles waited
    task automatic wait_upd(input int lim, output int n);
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while (o_apply_update !== 1'b1 && n < lim);
        if (o_apply_update !== 1'b1) begin
            chk(32'h0, 32'h1);
            wrap_up();
        end
    endtask : wait_upd
    task automatic do_reset();
        @(negedge i_mclk) i_nrst = 1'b0;
        repeat (10) @(negedge i_mclk);
        i_nrst = 1'b1;
    endtask : do_reset
    // main sequence
    initial begin
        do_reset();
        for (int s = 0; s < 8; s++) begin
            rd(3'(s), rv);
            chk(rv, 32'h0);
        end
        wr(pupc_pkg::SEL_CTRL1, 32'h0000_0060);
        for (int k = 0; k < 3; k++) begin
            dir = 16'($random(seed));
            val = 16'($random(seed));
            ext = 16'($random(seed));
            m.set_pins(1'b0, ext);
            wr(pupc_pkg::SEL_GPDIR, {16'h0, dir});
            wr(pupc_pkg::SEL_GPVAL, {16'h0, val});
            @(negedge i_mclk);
            chk({16'h0, o_gpio_pins_oe}, {16'h0, dir});
            chk({16'h0, o_gpio_pins & dir}, {16'h0, val & dir});
            repeat (4) @(negedge i_mclk);
            rd(pupc_pkg::SEL_GPVAL, rv);
            chk(rv, {16'h0, (val & dir) | (ext & ~dir)});
            rd(pupc_pkg::SEL_GPDIR, rv);
            chk(rv, {16'h0, dir});
        end
        wr(pupc_pkg::SEL_CTRL1, 32'h0000_0020);
        repeat (2) @(negedge i_mclk);
        chk({16'h0, o_gpio_pins_oe}, 32'h0);
        $display("test gpio done");
        for (int i = 0; i < 4; i++) begin
            wr(pupc_pkg::SEL_CTRL1, 32'(1 << i));
            repeat (3) @(negedge i_mclk);
            chk({28'h0, o_pd_refclk, o_pd_aux_dac, o_pd_main_dac, o_pd_digital}, 32'(1 << i));
            wr(pupc_pkg::SEL_GPDIR, 32'h0000_FFFF);
            wr(pupc_pkg::SEL_CTRL1, 32'h0);
            rd(pupc_pkg::SEL_GPDIR, rv);
            chk(rv, (i == 0) ? {16'h0, dir} : 32'h0000_FFFF);
        end
        for (int f = 0; f < 2; f++) begin
            wr(pupc_pkg::SEL_CTRL1, 32'(f << pupc_pkg::EXT_PD_FAST) | 32'h0000_0004);
            m.set_pins(1'b1, ext);
            repeat (5) @(negedge i_mclk);
            chk({26'h0, o_pd_pll_osc, o_pd_main_dac_bias, o_pd_refclk, o_pd_aux_dac,
                o_pd_main_dac, o_pd_digital}, f ? 32'hF : 32'h3F);
            m.set_pins(1'b0, ext);
        end
        $display("test power done");
        for (int p = 1; p < 9; p++) begin
            m.set_profile(3'(p));
            wait_upd(8, gap);
            chk({29'h0, o_active_profile}, 32'(p % 8));
        end
        $display("test profile done");
        wr(pupc_pkg::SEL_CTRL2, 32'h0000_0004);
        repeat (4) @(negedge i_mclk);
        chk(o_active_ctrl2, 32'h0);
        fork m.strobe(1); wait_upd(8, gap); join
        chk(o_active_ctrl2, 32'h0000_0004);
        $display("test strobe done");
        wr(pupc_pkg::SEL_RATE, 32'h0000_0004);
        for (int a = 0; a < 4; a++) begin
            wr(pupc_pkg::SEL_CTRL2, 32'(a << 1) | 32'h1);
            if (a == 0) fork m.strobe(6); wait_upd(8, gap); join
            else wait_upd(200, gap);
            wait_upd(600, gap);
            wait_upd(600, gap);
            chk(32'(gap), 32'(16 << a));
            chk({31'h0, o_update_pin_oe}, 32'h1);
        end
        $display("test auto done");
        wr(pupc_pkg::SEL_RATE, 32'h0000_0003);
        m.set_profile(3'h5);
        wait_upd(8, gap);
        repeat (10) @(negedge i_mclk);
        for (int c = 0; c < 40; c++) begin
            @(negedge i_mclk);
            chk({30'h0, o_update_pin, o_apply_update}, 32'h2);
        end
        $display("test static done");
        do_reset();
        @(negedge i_mclk);
        chk({30'h0, o_update_pin_oe, o_update_pin}, 32'h0);
        wrap_up();
    end
endmodule : tb_pupc_ctrl
bind pupc_ctrl pupc_ctrl_asserts u_chk (.i_mclk, .i_nrst, .i_reg_sel, .o_reg_rdata,
    .i_profile_pins, .i_update_pin, .o_update_pin, .o_update_pin_oe, .i_external_sleep_pin,
    .o_active_profile, .o_apply_update, .o_pd_digital, .o_pd_main_dac, .o_pd_main_dac_bias,
    .o_pd_aux_dac, .o_pd_refclk, .o_pd_pll_osc, .i_gpio_pins, .o_gpio_pins_oe);
